//--- logic/arsu_pkg.sv
// Shared constants and types of the analog raw scaling unit.
package arsu_pkg;
  // ============================================================
  // Register map, byte addresses on the Wishbone slave.
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_SRC = 8'h04;
  localparam logic [7:0] REG_TAB = 8'h08;
  localparam logic [7:0] REG_DST = 8'h0C;
  localparam logic [7:0] REG_CNT = 8'h10;
  localparam logic [7:0] REG_STAT = 8'h14;
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [15:0] BASE_RST = 16'h0000;
  localparam logic [15:0] CNT_RST = 16'h0001;
  // Status bit positions.
  localparam int ST_DONE = 0;
  localparam int ST_CERR = 1;
  localparam int ST_PERR = 2;
  localparam int ST_BUSY = 3;
  // ============================================================
  // Operation limits and scaling figures.
  localparam logic [15:0] CNT_MIN = 16'h0001;
  localparam logic [15:0] CNT_MAX = 16'h0040;
  localparam logic [7:0] POL_MAX = 8'h01;
  localparam logic signed [47:0] SCALE = 48'sh2710;
  localparam logic signed [16:0] FS12 = 17'sh0FFF;
  localparam logic signed [16:0] FS14 = 17'sh3FFF;
  localparam logic signed [16:0] MAX12 = 17'sh07FF;
  localparam logic signed [16:0] MAX14 = 17'sh1FFF;
  localparam logic signed [16:0] LZ12 = -17'sh04CD;
  localparam logic signed [16:0] LZ14 = -17'sh1334;
  localparam logic signed [16:0] LZB12 = 17'sh0199;
  localparam logic signed [16:0] LZB14 = 17'sh0666;
  // ============================================================
  // Types.
  typedef enum logic [1:0] {
    MD_CAL_SHARED,
    MD_CAL_ENTRY,
    MD_MUL_SHARED,
    MD_MUL_ENTRY
  } arsu_mode_t;
  typedef struct packed {
    logic [7:0] polarity_setting;
    logic rsv7;
    logic res14;
    arsu_mode_t scaling_mode;
    logic rsv3;
    logic linear_op;
    logic pulse_form;
    logic enable;
  } arsu_ctrl_t;
  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] data;
  } arsu_wr_t;
endpackage : arsu_pkg

//--- logic/arsu_wbuf.sv
// Two-entry write buffer between the datapath and register memory.
`timescale 1ns/10ps
module arsu_wbuf import arsu_pkg::*; (
  input wire logic clk_i, // Clock.
  input wire logic rst_i, // Synchronous reset.
  input wire logic in_valid_i, // Word offered.
  output logic in_ready_o, // Buffer can take a word.
  input wire arsu_wr_t in_i, // Offered word.
  output logic out_valid_o, // Head word valid.
  input wire logic out_ready_i, // Memory takes the head.
  output arsu_wr_t out_o // Head word.
);
  arsu_wr_t tail_ff;
  logic tail_v_ff;
  logic push;
  logic pop;

  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_valid_o <= 1'b0;
      tail_v_ff <= 1'b0;
      in_ready_o <= 1'b0;
      out_o <= '0;
      tail_ff <= '0;
    end else begin
      in_ready_o <= 1'b1;
      if (!out_valid_o || pop) begin
        if (tail_v_ff) begin
          out_o <= tail_ff;
          out_valid_o <= 1'b1;
          tail_v_ff <= 1'b0;
        end else begin
          out_o <= in_i;
          out_valid_o <= push;
        end
      end else if (push) begin
        tail_ff <= in_i;
        tail_v_ff <= 1'b1;
        in_ready_o <= 1'b0;
      end else begin
        in_ready_o <= !tail_v_ff;
      end
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_hold;
    out_valid_o && !out_ready_i |=> out_valid_o && $stable(out_o);
  endproperty
  a_hold: assert property (p_hold) else $error("Head word changed.");
endmodule : arsu_wbuf

//--- logic/arsu_div.sv
// Signed iterative divider, quotient truncated toward zero.
`timescale 1ns/10ps
module arsu_div #(
  parameter int NW = 48,
  parameter int DW = 32
) (
  input wire logic clk_i, // Clock.
  input wire logic rst_i, // Synchronous reset.
  input wire logic start_i, // Start pulse.
  input wire logic signed [NW-1:0] num_i, // Dividend.
  input wire logic signed [DW-1:0] den_i, // Divisor, never zero.
  output logic done_o, // Quotient ready pulse.
  output logic signed [NW-1:0] quo_o // Quotient.
);
  logic [NW-1:0] q_ff;
  logic [DW-1:0] d_ff;
  logic [DW:0] r_ff;
  logic [$clog2(NW+1)-1:0] cnt_ff;
  logic busy_ff;
  logic neg_ff;
  logic [DW:0] sh;
  logic fit;

  assign sh = {r_ff[DW-1:0], q_ff[NW-1]};
  assign fit = sh >= {1'b0, d_ff};
  assign quo_o = neg_ff ? -q_ff : q_ff;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_ff <= 1'b0;
      done_o <= 1'b0;
      q_ff <= '0;
      d_ff <= '0;
      r_ff <= '0;
      cnt_ff <= '0;
      neg_ff <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (start_i && !busy_ff) begin
        q_ff <= num_i[NW-1] ? -num_i : num_i;
        d_ff <= den_i[DW-1] ? -den_i : den_i;
        neg_ff <= num_i[NW-1] ^ den_i[DW-1];
        r_ff <= '0;
        cnt_ff <= ($clog2(NW+1))'(NW);
        busy_ff <= 1'b1;
      end else if (busy_ff) begin
        r_ff <= fit ? sh - {1'b0, d_ff} : sh;
        q_ff <= {q_ff[NW-2:0], fit};
        cnt_ff <= cnt_ff - 1'b1;
        if (cnt_ff == 1) begin
          busy_ff <= 1'b0;
          done_o <= 1'b1;
        end
      end
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_lat;
    start_i && !busy_ff |-> ##49 done_o;
  endproperty
  a_lat: assert property (p_lat) else $error("Divide latency.");
endmodule : arsu_div

//--- logic/arsu_core.sv
// Analog raw scaling unit: live-zero removal and linear scaling.
// Functional notes
// - Convert count source words into matching destination words.
// - Resolution select low gives 12-bit, high gives 14-bit operation.
// - Live-zero removal scales to 0..4095 or 0..16383.
// - Count outside 1..64 means no conversion, destination untouched.
// - Polarity setting is 0 unipolar or 1 bipolar, nothing else.
// - Linear scaling runs while enabled, or once per rising enable edge.
// - Two-point slope and offset scaled by 10000, then applied per word.
// - Multiplier-offset output is source times A over B plus C.
// - Mode 0 uses one shared two-point group of four words.
// - Mode 1 uses a four-word two-point group per entry.
// - Mode 2 uses one shared multiplier, divisor, offset group.
// - Mode 3 uses a three-word multiplier group per entry.
`timescale 1ns/10ps
module arsu_core import arsu_pkg::*; (
  input wire logic clk_i, // 20 MHz clock.
  input wire logic rst_i, // Synchronous reset, active high.
  input wire logic wb_cyc_i, // Wishbone cycle.
  input wire logic wb_stb_i, // Wishbone strobe.
  input wire logic wb_we_i, // Wishbone write enable.
  input wire logic [7:0] wb_adr_i, // Wishbone byte address.
  input wire logic [3:0] wb_sel_i, // Wishbone byte selects.
  input wire logic [31:0] wb_dat_i, // Wishbone write data.
  output logic [31:0] wb_dat_o, // Wishbone read data.
  output logic wb_ack_o, // Wishbone acknowledge.
  output logic mem_rd_o, // Memory read pulse.
  output logic [15:0] mem_addr_o, // Memory read address.
  input wire logic mem_rvalid_i, // Read data valid.
  input wire logic [15:0] mem_rdata_i, // Read data.
  output logic mem_wr_valid_o, // Memory write request.
  input wire logic mem_wr_ready_i, // Memory takes the write.
  output arsu_wr_t mem_wr_o // Memory write address and data.
);
  typedef enum logic [3:0] {
    S_IDLE, S_PRM, S_PRM_W, S_SRC, S_SRC_W, S_CALC,
    S_DIV_A, S_DIV_B, S_DIV_D, S_PUT, S_NEXT
  } arsu_state_t;

  arsu_state_t state_ff;
  arsu_ctrl_t ctrl_ff;
  arsu_ctrl_t run_ff;
  logic [15:0] src_ff, tab_ff, dst_ff, cnt_ff;
  logic done_ff, cerr_ff, perr_ff, pend_ff, en_d_ff;
  logic [5:0] idx_ff;
  logic [1:0] j_ff;
  logic [15:0] prm_ff [4];
  logic signed [15:0] smp_ff, b_ff, res_ff;
  logic signed [31:0] a_ff, den_ff;
  logic signed [47:0] num_ff, quo;
  logic go_ff, qdone, in_rdy;
  logic wb_req, trig, cnt_bad, par_bad, calc_bad, last, per_entry, lz_op;
  logic [2:0] kprm;
  logic signed [16:0] fs, mx, lz, span;
  logic signed [15:0] measured_low_point, measured_high_point, standard_low_point, standard_high_point;

  function automatic logic [15:0] wr16(input logic [15:0] old,
      input logic [31:0] dat, input logic [3:0] sel);
    wr16 = {sel[1] ? dat[15:8] : old[15:8], sel[0] ? dat[7:0] : old[7:0]};
  endfunction : wr16

  function automatic logic signed [15:0] sat16(input logic signed [47:0] v);
    if (v > 48'sh7FFF) sat16 = 16'sh7FFF;
    else if (v < -48'sh8000) sat16 = -16'sh8000;
    else sat16 = v[15:0];
  endfunction : sat16

  // ============================================================
  // Wishbone slave, one wait state: ack the cycle after the request.
  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= wb_req;
      unique case (wb_adr_i)
        REG_CTRL: wb_dat_o <= {16'h0000, ctrl_ff};
        REG_SRC: wb_dat_o <= {16'h0000, src_ff};
        REG_TAB: wb_dat_o <= {16'h0000, tab_ff};
        REG_DST: wb_dat_o <= {16'h0000, dst_ff};
        REG_CNT: wb_dat_o <= {16'h0000, cnt_ff};
        REG_STAT: wb_dat_o <= {28'h0000000, state_ff != S_IDLE,
                               perr_ff, cerr_ff, done_ff};
        default: wb_dat_o <= 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_ff <= CTRL_RST;
      src_ff <= BASE_RST;
      tab_ff <= BASE_RST;
      dst_ff <= BASE_RST;
      cnt_ff <= CNT_RST;
    end else if (wb_req && wb_we_i) begin
      unique case (wb_adr_i)
        REG_CTRL: ctrl_ff <= wr16(ctrl_ff, wb_dat_i, wb_sel_i);
        REG_SRC: src_ff <= wr16(src_ff, wb_dat_i, wb_sel_i);
        REG_TAB: tab_ff <= wr16(tab_ff, wb_dat_i, wb_sel_i);
        REG_DST: dst_ff <= wr16(dst_ff, wb_dat_i, wb_sel_i);
        REG_CNT: cnt_ff <= wr16(cnt_ff, wb_dat_i, wb_sel_i);
        default: ;
      endcase
    end
  end

  // ============================================================
  // Trigger: level form reruns while enabled, pulse form once per edge.
  assign trig = ctrl_ff.enable & (~ctrl_ff.pulse_form | pend_ff);
  assign cnt_bad = (cnt_ff < CNT_MIN) || (cnt_ff > CNT_MAX);
  assign par_bad = ~ctrl_ff.linear_op &&
    ctrl_ff.polarity_setting > POL_MAX;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      en_d_ff <= 1'b0;
      pend_ff <= 1'b0;
    end else begin
      en_d_ff <= ctrl_ff.enable;
      if (ctrl_ff.enable && !en_d_ff) pend_ff <= 1'b1;
      else if (state_ff == S_IDLE) pend_ff <= 1'b0;
    end
  end

  // Sticky status, cleared by writing one; a new event wins the clear.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      done_ff <= 1'b0;
      cerr_ff <= 1'b0;
      perr_ff <= 1'b0;
    end else begin
      if (state_ff == S_NEXT && last) done_ff <= 1'b1;
      else if (wb_req && wb_we_i && wb_adr_i == REG_STAT &&
               wb_sel_i[0] && wb_dat_i[ST_DONE]) done_ff <= 1'b0;
      if (state_ff == S_IDLE && trig && cnt_bad) cerr_ff <= 1'b1;
      else if (wb_req && wb_we_i && wb_adr_i == REG_STAT &&
               wb_sel_i[0] && wb_dat_i[ST_CERR]) cerr_ff <= 1'b0;
      if ((state_ff == S_IDLE && trig && par_bad) ||
          (state_ff == S_CALC && calc_bad)) perr_ff <= 1'b1;
      else if (wb_req && wb_we_i && wb_adr_i == REG_STAT &&
               wb_sel_i[0] && wb_dat_i[ST_PERR]) perr_ff <= 1'b0;
    end
  end

  // ============================================================
  // Datapath operand views.
  assign lz_op = ~run_ff.linear_op;
  assign per_entry = run_ff.scaling_mode[0];
  assign kprm = run_ff.scaling_mode[1] ? 3'h3 : 3'h4;
  assign last = idx_ff == 6'(cnt_ff - 16'h0001);
  assign measured_low_point = prm_ff[0];
  assign measured_high_point = prm_ff[1];
  assign standard_low_point = prm_ff[2];
  assign standard_high_point = prm_ff[3];
  assign fs = run_ff.res14 ? FS14 : FS12;
  assign mx = run_ff.res14 ? MAX14 : MAX12;
  assign lz = run_ff.polarity_setting[0] ? (run_ff.res14 ? LZB14 : LZB12)
                                         : (run_ff.res14 ? LZ14 : LZ12);
  assign span = mx - lz;
  assign calc_bad = run_ff.linear_op &&
    (run_ff.scaling_mode[1] ? prm_ff[1] == 16'h0000 : measured_low_point == measured_high_point);

  // ============================================================
  // Sequencer and arithmetic.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= S_IDLE;
      run_ff <= CTRL_RST;
      idx_ff <= '0;
      j_ff <= '0;
      prm_ff <= '{default: '0};
      smp_ff <= '0;
      a_ff <= '0;
      b_ff <= '0;
      res_ff <= '0;
      num_ff <= '0;
      den_ff <= '0;
      go_ff <= 1'b0;
      mem_rd_o <= 1'b0;
      mem_addr_o <= '0;
    end else begin
      go_ff <= 1'b0;
      mem_rd_o <= 1'b0;
      unique case (state_ff)
        S_IDLE: if (trig && !cnt_bad && !par_bad) begin
          run_ff <= ctrl_ff;
          idx_ff <= '0;
          j_ff <= '0;
          state_ff <= ctrl_ff.linear_op ? S_PRM : S_SRC;
        end
        S_PRM: begin
          mem_rd_o <= 1'b1;
          mem_addr_o <= tab_ff + 16'(j_ff) +
            (per_entry ? 16'(idx_ff) * 16'(kprm) : 16'h0000);
          state_ff <= S_PRM_W;
        end
        S_PRM_W: if (mem_rvalid_i) begin
          prm_ff[j_ff] <= mem_rdata_i;
          j_ff <= j_ff + 2'h1;
          state_ff <= (3'(j_ff) == kprm - 3'h1) ? S_SRC : S_PRM;
        end
        S_SRC: begin
          mem_rd_o <= 1'b1;
          mem_addr_o <= src_ff + 16'(idx_ff);
          state_ff <= S_SRC_W;
        end
        S_SRC_W: if (mem_rvalid_i) begin
          smp_ff <= mem_rdata_i;
          state_ff <= S_CALC;
        end
        S_CALC: begin
          if (lz_op) begin
            if (17'(smp_ff) <= lz) begin
              res_ff <= '0;
              state_ff <= S_PUT;
            end else begin
              num_ff <= (48'(smp_ff) - 48'(lz)) * 48'(fs) +
                        48'(span >>> 1);
              den_ff <= 32'(span);
              go_ff <= 1'b1;
              state_ff <= S_DIV_D;
            end
          end else if (calc_bad) begin
            state_ff <= S_NEXT;
          end else if (run_ff.scaling_mode[1]) begin
            num_ff <= 48'(smp_ff) *
                      48'(signed'({1'b0, prm_ff[0]}));
            den_ff <= 32'(prm_ff[1]);
            go_ff <= 1'b1;
            state_ff <= S_DIV_D;
          end else begin
            num_ff <= (48'(standard_low_point) - 48'(standard_high_point)) * SCALE;
            den_ff <= 32'(measured_low_point) - 32'(measured_high_point);
            go_ff <= 1'b1;
            state_ff <= S_DIV_A;
          end
        end
        S_DIV_A: if (qdone) begin
          a_ff <= quo[31:0];
          num_ff <= 48'(measured_low_point) * quo;
          den_ff <= 32'(SCALE);
          go_ff <= 1'b1;
          state_ff <= S_DIV_B;
        end
        S_DIV_B: if (qdone) begin
          b_ff <= sat16(48'(standard_low_point) - quo);
          num_ff <= 48'(smp_ff) * 48'(a_ff);
          den_ff <= 32'(SCALE);
          go_ff <= 1'b1;
          state_ff <= S_DIV_D;
        end
        S_DIV_D: if (qdone) begin
          if (lz_op) res_ff <= quo > 48'(fs) ? 16'(fs) : quo[15:0];
          else if (run_ff.scaling_mode[1])
            res_ff <= sat16(quo + 48'(signed'(prm_ff[2])));
          else res_ff <= sat16(quo + 48'(b_ff));
          state_ff <= S_PUT;
        end
        S_PUT: if (in_rdy) state_ff <= S_NEXT;
        S_NEXT: if (last) begin
          state_ff <= S_IDLE;
        end else begin
          idx_ff <= idx_ff + 6'h01;
          j_ff <= '0;
          state_ff <= (run_ff.linear_op && per_entry) ? S_PRM : S_SRC;
        end
        default: state_ff <= S_IDLE;
      endcase
    end
  end

  arsu_div #(.NW(48), .DW(32)) u_div (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(go_ff),
    .num_i(num_ff),
    .den_i(den_ff),
    .done_o(qdone),
    .quo_o(quo)
  );

  arsu_wbuf u_wbuf (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_valid_i(state_ff == S_PUT),
    .in_ready_o(in_rdy),
    .in_i({dst_ff + 16'(idx_ff), res_ff}),
    .out_valid_o(mem_wr_valid_o),
    .out_ready_i(mem_wr_ready_i),
    .out_o(mem_wr_o)
  );

  // ============================================================
  // Checks.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_cnt;
    state_ff == S_IDLE && trig && cnt_bad |=> state_ff == S_IDLE && cerr_ff;
  endproperty
  a_cnt: assert property (p_cnt) else $error("Bad count ran.");
  property p_pol;
    state_ff == S_IDLE && trig && par_bad |=> state_ff == S_IDLE && perr_ff;
  endproperty
  a_pol: assert property (p_pol) else $error("Bad polarity ran.");
  property p_fs12;
    state_ff == S_PUT && lz_op && !run_ff.res14 |-> res_ff <= 16'h0FFF;
  endproperty
  a_fs12: assert property (p_fs12) else $error("12-bit span.");
  property p_fs14;
    state_ff == S_PUT && lz_op |-> res_ff >= 0 && res_ff <= 16'sh3FFF;
  endproperty
  a_fs14: assert property (p_fs14) else $error("14-bit span.");
  property p_clamp;
    state_ff == S_CALC && lz_op && 17'(smp_ff) <= lz
      |=> state_ff == S_PUT && res_ff == 0;
  endproperty
  a_clamp: assert property (p_clamp) else $error("No clamp.");
  property p_adv;
    state_ff == S_NEXT && !last |=> idx_ff == $past(idx_ff) + 6'h01;
  endproperty
  a_adv: assert property (p_adv) else $error("Index skip.");
  property p_once;
    state_ff == S_NEXT && last && run_ff.pulse_form && ctrl_ff.pulse_form
      && !(ctrl_ff.enable && !en_d_ff) |=> ##1 state_ff == S_IDLE;
  endproperty
  a_once: assert property (p_once) else $error("Pulse rerun.");
  property p_entry;
    state_ff == S_NEXT && !last && run_ff.linear_op && per_entry
      |=> state_ff == S_PRM;
  endproperty
  a_entry: assert property (p_entry) else $error("No reload.");
  property p_shared;
    state_ff == S_NEXT && !last && !per_entry |=> state_ff == S_SRC;
  endproperty
  a_shared: assert property (p_shared) else $error("Reload.");
  property p_zdiv;
    state_ff == S_CALC && run_ff.linear_op && run_ff.scaling_mode[1]
      && prm_ff[1] == 16'h0000 |=> perr_ff && state_ff == S_NEXT;
  endproperty
  a_zdiv: assert property (p_zdiv) else $error("Zero divisor.");
  c_lz: cover property (state_ff == S_PUT && lz_op && in_rdy);
  c_cal: cover property (state_ff == S_PUT && !per_entry && !lz_op);
  c_mul: cover property (state_ff == S_PUT && run_ff.scaling_mode[1]);
endmodule : arsu_core

//--- testbench/arsu_mem_model.sv
// Register memory model that answers the scaling unit's reads and writes.
`timescale 1ns/10ps
module arsu_mem_model import arsu_pkg::*; (
  input wire logic clk_i, // Clock.
  input wire logic rst_i, // Synchronous reset.
  input wire logic slow_i, // Late answers and long write stalls.
  input wire logic mem_rd_i, // Read pulse.
  input wire logic [15:0] mem_addr_i, // Read address.
  output logic mem_rvalid_o, // Read data valid.
  output logic [15:0] mem_rdata_o, // Read data.
  input wire logic mem_wr_valid_i, // Write request.
  output logic mem_wr_ready_o, // Write taken.
  input wire arsu_wr_t mem_wr_i // Write address and data.
);
  logic [15:0] mem [0:1023];
  logic [15:0] raddr_ff;
  logic [2:0] dly_ff;
  logic pend_ff;
  logic [9:0] cnt_ff;
  int n_wr = 0;
  // Long stalls in slow mode fill the result buffer behind the port.
  assign mem_wr_ready_o = !slow_i || (cnt_ff[9:7] == 3'h7);
  always @(posedge clk_i) begin
    cnt_ff <= cnt_ff + 10'h001;
    mem_rvalid_o <= 1'b0;
    mem_rdata_o <= ~mem_rdata_o;
    if (rst_i) begin
      pend_ff <= 1'b0;
      cnt_ff <= 10'h000;
      mem_rdata_o <= 16'h5AA5;
    end else if (mem_rd_i) begin
      pend_ff <= 1'b1;
      dly_ff <= slow_i ? 3'h4 : 3'h0;
      raddr_ff <= mem_addr_i;
    end else if (pend_ff && dly_ff == 3'h0) begin
      pend_ff <= 1'b0;
      mem_rvalid_o <= 1'b1;
      mem_rdata_o <= mem[raddr_ff[9:0]];
    end else if (pend_ff) begin
      dly_ff <= dly_ff - 3'h1;
    end
    if (!rst_i && mem_wr_valid_i && mem_wr_ready_o) begin
      mem[mem_wr_i.addr[9:0]] <= mem_wr_i.data;
      n_wr <= n_wr + 1;
    end
  end
endmodule : arsu_mem_model

//--- testbench/testbench.sv
// Self-checking bench for the analog raw scaling unit.
`timescale 1ns/10ps
module testbench import arsu_pkg::*;;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic slow = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat;
  logic [15:0] maddr, mrdata;
  logic ack, rd, rvalid, wr_valid, wr_ready;
  arsu_wr_t wr_w;
  int n_mismatch = 0;
  int compares = 0;
  logic [15:0] ctl_bad_n [2] = '{16'h0000, 16'h0041};
  always #25 clk_i = ~clk_i;
  arsu_core dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .mem_rd_o(rd),
    .mem_addr_o(maddr), .mem_rvalid_i(rvalid), .mem_rdata_i(mrdata),
    .mem_wr_valid_o(wr_valid), .mem_wr_ready_i(wr_ready),
    .mem_wr_o(wr_w));
  arsu_mem_model mem_u (.clk_i(clk_i), .rst_i(rst_i), .slow_i(slow),
    .mem_rd_i(rd), .mem_addr_i(maddr), .mem_rvalid_o(rvalid),
    .mem_rdata_o(mrdata), .mem_wr_valid_i(wr_valid),
    .mem_wr_ready_o(wr_ready), .mem_wr_i(wr_w));
  // ============================================================
  // Reporting and bus tasks.
  task automatic conclude;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : conclude
  task automatic chk(input string nm, input logic [31:0] e,
      input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic tick(inout int i);
    @(posedge clk_i);
    i++;
    if (i > 40000) begin
      n_mismatch++;
      $display("BAD wait limit exp done got hang");
      conclude();
    end
  endtask : tick
  task automatic wb(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q);
    int i;
    i = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hF;
    do tick(i); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] m,
      input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0000_0000, q);
    chk($sformatf("reg %h", a), e, q & m);
  endtask : rdc
  // ============================================================
  // Operation helpers.
  function automatic logic [15:0] ctl(input logic lin,
      input logic [1:0] md, input logic r14, input logic [7:0] pol,
      input logic pulse);
    return {pol, 1'b0, r14, md, 1'b0, lin, pulse, 1'b1};
  endfunction : ctl
  task automatic ld(input int a, input logic [15:0] v[$]);
    foreach (v[k]) mem_u.mem[a + k] = v[k];
  endtask : ld
  task automatic cmp(input int a, input logic [15:0] v[$]);
    foreach (v[k]) chk($sformatf("word %0d", a + k), {16'h0, v[k]},
      {16'h0, mem_u.mem[a + k]});
  endtask : cmp
  // Runs one operation and waits until the unit is idle again.
  task automatic run(input logic [15:0] c, input logic [15:0] n,
      input int nw);
    int base;
    int i;
    logic [31:0] q;
    i = 0;
    for (int k = 0; k < 8; k++) mem_u.mem[300 + k] = 16'h5A5A;
    base = mem_u.n_wr;
    wr(REG_CNT, {16'h0000, n});
    wr(REG_CTRL, {16'h0000, c});
    while (mem_u.n_wr - base < nw) tick(i);
    wr(REG_CTRL, 32'h0000_0000);
    do begin
      wb(1'b0, REG_STAT, 32'h0000_0000, q);
      tick(i);
    end while (q[ST_BUSY] !== 1'b0);
    if (c[1]) chk("write count", nw, mem_u.n_wr - base);
  endtask : run
  // ============================================================
  // Main sequence.
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    rdc(REG_CTRL, 32'hFFFF_FFFF, 32'h0000_0000);
    rdc(REG_CNT, 32'hFFFF_FFFF, 32'h0000_0001);
    rdc(REG_STAT, 32'hFFFF_FFFF, 32'h0000_0000);
    wr(8'h18, 32'h0000_1234);
    rdc(8'h18, 32'hFFFF_FFFF, 32'h0000_0000);
    wr(REG_SRC, 32'h0000_0064);
    wr(REG_TAB, 32'h0000_00C8);
    wr(REG_DST, 32'h0000_012C);
    rdc(REG_DST, 32'hFFFF_FFFF, 32'h0000_012C);
    ld(100, '{16'hFB33, 16'h07FF, 16'hF800});
    run(ctl(1'b0, 2'h0, 1'b0, 8'h00, 1'b1), 16'h3, 3);
    cmp(300, '{16'h0000, 16'h0FFF, 16'h0000, 16'h5A5A});
    rdc(REG_STAT, 32'h0000_0001, 32'h0000_0001);
    ld(100, '{16'hECCC, 16'h0665, 16'h1FFF, 16'hE000});
    run(ctl(1'b0, 2'h0, 1'b1, 8'h00, 1'b1), 16'h4, 4);
    cmp(300, '{16'h0000, 16'h1FFF, 16'h3FFF, 16'h0000});
    ld(100, '{16'h0199, 16'h07FF, 16'h0000});
    run(ctl(1'b0, 2'h0, 1'b0, 8'h01, 1'b1), 16'h3, 3);
    cmp(300, '{16'h0000, 16'h0FFF, 16'h0000});
    run(ctl(1'b0, 2'h0, 1'b0, 8'h02, 1'b1), 16'h3, 0);
    cmp(300, '{16'h5A5A, 16'h5A5A});
    rdc(REG_STAT, 32'h0000_0004, 32'h0000_0004);
    wr(REG_STAT, 32'h0000_0004);
    foreach (ctl_bad_n[k]) begin
      run(ctl(k[0], 2'h2, 1'b0, 8'h00, 1'b1), ctl_bad_n[k], 0);
      cmp(300, '{16'h5A5A});
      rdc(REG_STAT, 32'h0000_0002, 32'h0000_0002);
      wr(REG_STAT, 32'h0000_0002);
      rdc(REG_STAT, 32'h0000_0002, 32'h0000_0000);
    end
    ld(100, '{16'h0190, 16'hFE70, 16'h0FA0, 16'h0001});
    ld(200, '{16'h0000, 16'h0FA0, 16'h0000, 16'h2710});
    run(ctl(1'b1, 2'h0, 1'b0, 8'h00, 1'b1), 16'h4, 4);
    cmp(300, '{16'h03E8, 16'hFC18, 16'h2710, 16'h0002});
    ld(100, '{16'h0190, 16'h0096, 16'h0001, 16'h0FA0});
    ld(204, '{16'h00C8, 16'h0064, 16'h03E8, 16'h07D0, 16'h0005,
      16'h0005, 16'h0000, 16'h0001, 16'h0000, 16'h0FA0, 16'h0000,
      16'h2710});
    run(ctl(1'b1, 2'h1, 1'b0, 8'h00, 1'b1), 16'h4, 3);
    cmp(300, '{16'h03E8, 16'h05DC, 16'h5A5A, 16'h2710});
    rdc(REG_STAT, 32'h0000_0004, 32'h0000_0004);
    wr(REG_STAT, 32'h0000_0004);
    ld(100, '{16'h2000, 16'h3FFF, 16'h1FFE, 16'h0000, 16'h0100});
    ld(200, '{16'h2710, 16'h3FFF, 16'h0000});
    run(ctl(1'b1, 2'h2, 1'b0, 8'h00, 1'b0), 16'h4, 8);
    cmp(300, '{16'h1388, 16'h2710, 16'h1387, 16'h0000});
    slow <= 1'b1;
    ld(200, '{16'h1388, 16'h3FFC, 16'h0001, 16'h2710, 16'h3FFF, 16'h0000,
      16'h0898, 16'h3FFC, 16'hFF38, 16'h0640, 16'h3FFF, 16'hFF9C,
      16'h0001, 16'h0000, 16'h0000});
    run(ctl(1'b1, 2'h3, 1'b0, 8'h00, 1'b1), 16'h5, 4);
    cmp(300, '{16'h09C5, 16'h2710, 16'h0384, 16'hFF9C,
      16'h5A5A});
    rdc(REG_STAT, 32'h0000_0004, 32'h0000_0004);
    conclude();
  end
endmodule : testbench
